/* File: hdl/hlb_list_ports.sv */
// What this block does
// - Command 2D reads the pending readback byte count of iso half zero.
// - Command 2E reads the pending readback byte count of iso half one.
// - Iso list port: 40H reads, C0H writes, one 16-bit word per access.
// - Iso port puts even-address byte in bits 15:8, odd in 7:0.
// - Ack port puts odd-address byte in bits 15:8, even in 7:0.
// - Ack list port: 41H reads, C1H writes, one 16-bit word per access.
// - Each word moved advances the buffer byte pointer by two.
// - Pointer reaching the count raises end of transfer and updates status.
// - Status holds per-buffer done flags and full flags.
// - Ack length plus twice the iso length must stay within 4 kbytes.
`timescale 1ns/100ps
`include "hlb_defines.svh"
module hlb_list_ports #(
	parameter int RAM_BYTES = `HLB_RAM_BYTES,
	parameter int FIFO_DEPTH = `HLB_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Processor command strobe
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	// Processor word write
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [15:0] wr_data,
	// Processor word read
	input wire logic rd_req,
	output logic rd_ready,
	output logic rd_valid,
	output logic [15:0] rd_data,
	// Transfer setup from the register file
	input wire logic [15:0] byte_transfer_counter,
	input wire logic [15:0] iso_buffer_length,
	input wire logic [15:0] ack_buffer_length,
	input wire logic iso_half_sel,
	// Status and events
	output hlb_pkg::hlb_status_t buffer_status_flags,
	output logic end_of_transfer,
	output logic all_transfer_end_irq,
	output logic cfg_overflow,
	// Controller side of the buffer memory
	input wire logic [1:0] sie_len_load,
	input wire logic [15:0] sie_len_value,
	input wire logic [2:0] sie_consumed,
	input wire logic sie_wr_en,
	input wire logic [11:0] sie_addr,
	input wire logic [7:0] sie_wdata,
	output logic [7:0] sie_rdata
);
	import hlb_pkg::*;

	localparam int AW = 12;

	initial begin
		if (RAM_BYTES < 4 || RAM_BYTES > (1 << AW) || FIFO_DEPTH < 2) begin
			$error("hlb_list_ports: RAM_BYTES must lie in 4..4096");
		end
	end

	logic [7:0] mem [RAM_BYTES];
	hlb_mode_e mode_reg, mode_next;
	logic [1:0] buf_reg, buf_next;
	logic [15:0] ptr_reg, ptr_next;
	logic [15:0] pend_reg [2];
	logic [15:0] pend_next [2];
	logic [15:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic eot_reg, eot_next;
	hlb_status_t stat_reg, stat_next;
	logic [2:0] full_set, full_clr, done_set, done_clr;
	logic [15:0] base;
	logic [AW-1:0] addr, addr_odd;
	logic [7:0] even_b, odd_b;
	logic is_ack, is_write, port_mode;
	logic rd_take, wr_take, word_move, reach;
	hlb_wword_s fin, fout;
	logic fout_valid, drain;

	assign is_ack = (mode_reg == HLB_ACK_RD) || (mode_reg == HLB_ACK_WR);
	assign is_write = (mode_reg == HLB_ISO_WR) || (mode_reg == HLB_ACK_WR);
	assign port_mode = (mode_reg == HLB_ISO_RD) || (mode_reg == HLB_ISO_WR) || is_ack;

	// Half one follows half zero, ack list follows both halves
	always_comb begin
		base = '0;
		if (is_ack) begin
			base = {iso_buffer_length[14:0], 1'b0};
		end else if (buf_reg == 2'(`HLB_BUF_ISO1)) begin
			base = iso_buffer_length;
		end
	end
	assign addr = AW'(base + ptr_reg);
	assign addr_odd = AW'(addr + 1'b1);
	assign even_b = mem[addr];
	assign odd_b = mem[addr_odd];

	assign cfg_overflow = ({2'b00, ack_buffer_length} + {1'b0, iso_buffer_length, 1'b0})
		> 18'(`HLB_RAM_LIMIT);

	// Reads wait until every queued write has landed in memory
	assign rd_ready = !fout_valid;
	assign rd_take = rd_req && rd_ready && !cmd_valid;
	assign wr_take = wr_valid && wr_ready && !cmd_valid && is_write;
	assign word_move = port_mode && ((rd_take && !is_write) || wr_take);
	assign reach = (ptr_reg < byte_transfer_counter) &&
		(({1'b0, ptr_reg} + 17'(`HLB_PTR_STEP)) >= {1'b0, byte_transfer_counter});

	always_comb begin
		fin.addr = addr;
		fin.even_b = is_ack ? wr_data[7:0] : wr_data[15:8];
		fin.odd_b = is_ack ? wr_data[15:8] : wr_data[7:0];
	end

	// Controller memory writes have priority; the write queue then backs up
	assign drain = fout_valid && !sie_wr_en;

	hlb_fifo #(
		.WIDTH($bits(hlb_wword_s)),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clock(clock),
		.rst(rst),
		.in_valid(wr_valid && is_write && !cmd_valid),
		.in_ready(wr_ready),
		.in_data(fin),
		.out_valid(fout_valid),
		.out_ready(!sie_wr_en),
		.out_data(fout)
	);

	always_comb begin
		mode_next = mode_reg;
		buf_next = buf_reg;
		ptr_next = ptr_reg;
		rd_data_next = rd_data_reg;
		rd_valid_next = 1'b0;
		eot_next = 1'b0;
		if (cmd_valid) begin
			ptr_next = '0;
			buf_next = iso_half_sel ? 2'(`HLB_BUF_ISO1) : 2'(`HLB_BUF_ISO0);
			case (cmd_code)
				`HLB_CMD_ISO0_LEN_RD: mode_next = HLB_LEN0;
				`HLB_CMD_ISO1_LEN_RD: mode_next = HLB_LEN1;
				`HLB_CMD_ISO_RD: mode_next = HLB_ISO_RD;
				`HLB_CMD_ISO_WR: mode_next = HLB_ISO_WR;
				`HLB_CMD_ACK_RD: begin
					mode_next = HLB_ACK_RD;
					buf_next = 2'(`HLB_BUF_ACK);
				end
				`HLB_CMD_ACK_WR: begin
					mode_next = HLB_ACK_WR;
					buf_next = 2'(`HLB_BUF_ACK);
				end
				default: mode_next = HLB_IDLE;
			endcase
		end else begin
			if (rd_take) begin
				rd_valid_next = 1'b1;
				case (mode_reg)
					HLB_LEN0: rd_data_next = pend_reg[0];
					HLB_LEN1: rd_data_next = pend_reg[1];
					HLB_ISO_RD: rd_data_next = {even_b, odd_b};
					HLB_ACK_RD: rd_data_next = {odd_b, even_b};
					default: rd_data_next = `HLB_WORD_RESET;
				endcase
			end
			if (word_move) begin
				ptr_next = ptr_reg + `HLB_PTR_STEP;
			end
		end
		// end of transfer on reaching the count
		if (word_move && reach) begin
			eot_next = 1'b1;
		end
	end

	always_comb begin
		full_set = '0;
		full_clr = sie_consumed;
		done_set = sie_consumed;
		done_clr = '0;
		full_set[1:0] = sie_len_load;
		if (cmd_valid && (cmd_code == `HLB_CMD_ACK_WR)) begin
			done_clr[`HLB_BUF_ACK] = 1'b1;
		end
		if (cmd_valid && (cmd_code == `HLB_CMD_ISO_WR)) begin
			done_clr[iso_half_sel] = 1'b1;
		end
		if (eot_next) begin
			full_set[buf_reg] = is_write;
			full_clr[buf_reg] = full_clr[buf_reg] | !is_write;
		end
	end

	generate
		for (genvar i = 0; i < 3; i++) begin : g_flag
			// Set wins over a clear in the same cycle
			assign stat_next[i] = full_set[i] || (stat_reg[i] && !full_clr[i]);
			assign stat_next[i+`HLB_DONE_OFS] = done_set[i] ||
				(stat_reg[i+`HLB_DONE_OFS] && !done_clr[i]);
		end
	endgenerate

	always_comb begin
		pend_next[0] = sie_len_load[0] ? sie_len_value : pend_reg[0];
		pend_next[1] = sie_len_load[1] ? sie_len_value : pend_reg[1];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_reg <= HLB_IDLE;
			buf_reg <= '0;
			ptr_reg <= '0;
			pend_reg[0] <= '0;
			pend_reg[1] <= '0;
			rd_data_reg <= `HLB_WORD_RESET;
			rd_valid_reg <= 1'b0;
			eot_reg <= 1'b0;
			stat_reg <= '0;
		end else begin
			mode_reg <= mode_next;
			buf_reg <= buf_next;
			ptr_reg <= ptr_next;
			pend_reg[0] <= pend_next[0];
			pend_reg[1] <= pend_next[1];
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			eot_reg <= eot_next;
			stat_reg <= stat_next;
		end
	end

	always_ff @(posedge clock) begin
		sie_rdata <= mem[sie_addr];
		if (sie_wr_en) begin
			mem[sie_addr] <= sie_wdata;
		end else if (drain) begin
			mem[fout.addr] <= fout.even_b;
			mem[AW'(fout.addr + 1'b1)] <= fout.odd_b;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign end_of_transfer = eot_reg;
	assign all_transfer_end_irq = eot_reg;
	assign buffer_status_flags = stat_reg;

	len0_read_a: assert property (@(posedge clock) disable iff (rst)
		rd_take && mode_reg == HLB_LEN0 |=> rd_valid && rd_data == $past(pend_reg[0]))
		else $error("half zero length read wrong");
	len1_read_a: assert property (@(posedge clock) disable iff (rst)
		rd_take && mode_reg == HLB_LEN1 |=> rd_data == $past(pend_reg[1]))
		else $error("half one length read wrong");
	cmd_decode_a: assert property (@(posedge clock) disable iff (rst)
		cmd_valid && cmd_code == 8'hC0 |=> mode_reg == HLB_ISO_WR && ptr_reg == 16'h0000)
		else $error("iso write command not decoded");
	ack_decode_a: assert property (@(posedge clock) disable iff (rst)
		cmd_valid && cmd_code == 8'h41 |=> mode_reg == HLB_ACK_RD && buf_reg == 2'd2)
		else $error("ack read command not decoded");
	iso_order_a: assert property (@(posedge clock) disable iff (rst)
		rd_take && mode_reg == HLB_ISO_RD |=> rd_data[15:8] == $past(mem[addr]))
		else $error("iso byte order wrong");
	ack_order_a: assert property (@(posedge clock) disable iff (rst)
		rd_take && mode_reg == HLB_ACK_RD |=> rd_data[7:0] == $past(mem[addr]))
		else $error("ack byte order wrong");
	ptr_step_a: assert property (@(posedge clock) disable iff (rst)
		word_move |=> ptr_reg == $past(ptr_reg) + 16'h0002)
		else $error("pointer did not advance by two");
	eot_reach_a: assert property (@(posedge clock) disable iff (rst)
		end_of_transfer |-> $past(word_move) && $past(ptr_next) >= $past(byte_transfer_counter))
		else $error("end of transfer without reaching count");
	full_write_a: assert property (@(posedge clock) disable iff (rst)
		end_of_transfer && $past(mode_reg) == HLB_ACK_WR |-> buffer_status_flags[2])
		else $error("ack full flag not set");
	reset_zero_a: assert property (@(posedge clock)
		rst |=> rd_data == 16'h0000 && pend_reg[0] == 16'h0000 && !end_of_transfer)
		else $error("state not zero after reset");
endmodule

/* File: shared/hlb_defines.svh */
`ifndef HLB_DEFINES_SVH
`define HLB_DEFINES_SVH

// Command codes seen on the processor register port
`define HLB_CMD_ISO0_LEN_RD 8'h2D
`define HLB_CMD_ISO1_LEN_RD 8'h2E
`define HLB_CMD_ISO_RD 8'h40
`define HLB_CMD_ISO_WR 8'hC0
`define HLB_CMD_ACK_RD 8'h41
`define HLB_CMD_ACK_WR 8'hC1

// Buffer memory and pointer
`define HLB_RAM_BYTES 4096
`define HLB_RAM_LIMIT 17'h01000
`define HLB_PTR_STEP 16'h0002
`define HLB_WORD_RESET 16'h0000
`define HLB_FIFO_DEPTH 32

// Buffer indices; done flag of buffer i sits at i + 3, full flag at i
`define HLB_BUF_ISO0 0
`define HLB_BUF_ISO1 1
`define HLB_BUF_ACK 2
`define HLB_DONE_OFS 3

`endif

/* File: shared/hlb_pkg.sv */
package hlb_pkg;

	typedef enum logic [2:0] {
		HLB_IDLE = 3'b000,
		HLB_LEN0 = 3'b001,
		HLB_LEN1 = 3'b010,
		HLB_ISO_RD = 3'b011,
		HLB_ISO_WR = 3'b100,
		HLB_ACK_RD = 3'b101,
		HLB_ACK_WR = 3'b110
	} hlb_mode_e;

	// One word on its way into the buffer memory, already in byte order
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] even_b;
		logic [7:0] odd_b;
	} hlb_wword_s;

	typedef logic [5:0] hlb_status_t;

endpackage

/* File: hdl/hlb_fifo.sv */
`timescale 1ns/100ps
module hlb_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
			$error("hlb_fifo: DEPTH must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rp_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_next = push ? wp_reg + 1'b1 : wp_reg;
		rp_next = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end
endmodule

/* File: sim/hlb_host_model.sv */
`timescale 1ns/100ps
module hlb_host_model (
	// Clock
	input wire logic clock,
	// Command and word strobes toward the block
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [15:0] wr_data,
	output logic rd_req,
	input wire logic rd_ready,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	// Raised when a handshake never completes
	output logic hang
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		wr_valid = 1'b0;
		wr_data = 16'h0000;
		rd_req = 1'b0;
		hang = 1'b0;
	end
	task automatic step();
		@(posedge clock);
		#1;
	endtask
	task automatic send_cmd(input logic [7:0] code);
		cmd_code = code;
		cmd_valid = 1'b1;
		step();
		cmd_valid = 1'b0;
	endtask
	task automatic write_word(input logic [15:0] w, input logic last);
		int n;
		n = 0;
		wr_data = w;
		if (wr_valid !== 1'b1) wr_valid = 1'b1;
		while (wr_ready !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		hang = n >= 200;
		step();
		if (last) release_bus();
	endtask
	task automatic read_word(output logic [15:0] w, input logic last);
		int n;
		n = 0;
		if (rd_req !== 1'b1) rd_req = 1'b1;
		while (rd_ready !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		step();
		if (last) rd_req = 1'b0;
		hang = rd_valid !== 1'b1 || n >= 200;
		w = rd_data;
	endtask
	// Released data lines no longer hold the last word
	task automatic release_bus();
		wr_valid = 1'b0;
		wr_data = ~wr_data;
	endtask
endmodule

/* File: sim/tb_host_list_buffer_ram_ports.sv */
`timescale 1ns/100ps
`include "hlb_defines.svh"
`define CHECK(g, e) chk(16'(g), 16'(e))
module tb_host_list_buffer_ram_ports;
	import hlb_pkg::*;
	logic clock = 1'b0, rst = 1'b1, iso_half_sel = 1'b0, sie_wr_en = 1'b0;
	logic cmd_valid, wr_valid, wr_ready, rd_req, rd_ready, rd_valid, hang;
	logic end_of_transfer, all_transfer_end_irq, cfg_overflow;
	logic [7:0] cmd_code, sie_rdata, sie_wdata = 8'hEE;
	logic [15:0] wr_data, rd_data, w, byte_transfer_counter = 16'h0000;
	logic [15:0] iso_buffer_length = 16'h0020, ack_buffer_length = 16'h0020;
	logic [15:0] sie_len_value = 16'h0000;
	logic [1:0] sie_len_load = 2'b00;
	logic [2:0] sie_consumed = 3'b000;
	logic [11:0] sie_addr = 12'hFFF;
	hlb_status_t buffer_status_flags;
	int bad_count = 0, n_tests = 0, eot_n = 0, irq_n = 0, e0, k;

	hlb_list_ports dut (.clock, .rst, .cmd_valid, .cmd_code, .wr_valid, .wr_ready, .wr_data,
		.rd_req, .rd_ready, .rd_valid, .rd_data, .byte_transfer_counter, .iso_buffer_length,
		.ack_buffer_length, .iso_half_sel, .buffer_status_flags, .end_of_transfer,
		.all_transfer_end_irq, .cfg_overflow, .sie_len_load, .sie_len_value, .sie_consumed,
		.sie_wr_en, .sie_addr, .sie_wdata, .sie_rdata);
	hlb_host_model host (.clock, .cmd_valid, .cmd_code, .wr_valid, .wr_ready, .wr_data,
		.rd_req, .rd_ready, .rd_valid, .rd_data, .hang);

	always #20 clock = ~clock;
	always @(posedge clock) begin
		if (end_of_transfer === 1'b1) eot_n++;
		if (all_transfer_end_irq === 1'b1) irq_n++;
	end
	always @(posedge hang) begin
		bad_count++;
		complete_run();
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("Mismatches %0d in %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Wait until the write queue has emptied into memory
	task automatic drain();
		int n;
		n = 0;
		while (rd_ready !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		if (n >= 100) begin
			bad_count++;
			complete_run();
		end
		step(3);
	endtask
	task automatic peek(input logic [11:0] a, input logic [7:0] e);
		sie_addr = a;
		step(1);
		`CHECK(sie_rdata, e);
	endtask
	task automatic rd_chk(input logic [15:0] e);
		host.read_word(w, 1'b1);
		`CHECK(w, e);
	endtask
	// Memory byte at offset a from a list base holds base value plus a
	function automatic logic [15:0] pat(input int k, input logic ack);
		logic [7:0] ev;
		ev = (ack ? 8'h50 : 8'h10) + 8'(2 * k);
		return ack ? {ev + 8'h01, ev} : {ev, ev + 8'h01};
	endfunction

	initial begin
		step(8);
		rst = 1'b0;
		`CHECK(rd_data, 0); // port after reset
		`CHECK(buffer_status_flags, 0); // flags after reset
		host.send_cmd(`HLB_CMD_ISO0_LEN_RD);
		rd_chk(16'h0000); // length after reset
		sie_len_value = 16'h0012;
		sie_len_load = 2'b01;
		step(1);
		sie_len_value = 16'h0034;
		sie_len_load = 2'b10;
		step(1);
		sie_len_load = 2'b00;
		step(1);
		`CHECK(buffer_status_flags, 6'h03); // both halves full
		host.send_cmd(`HLB_CMD_ISO0_LEN_RD);
		rd_chk(16'h0012); // half zero count
		host.send_cmd(`HLB_CMD_ISO1_LEN_RD);
		rd_chk(16'h0034); // half one count
		byte_transfer_counter = 16'h0012; // count from half zero
		e0 = eot_n;
		host.send_cmd(`HLB_CMD_ISO_WR); // write command
		for (k = 0; k < 9; k++)
			host.write_word(pat(k, 1'b0), k == 8); // byte count, word moves
		drain();
		`CHECK(eot_n - e0, 1); // end reached
		peek(12'h004, 8'h14); // even byte high
		peek(12'h011, 8'h21); // odd byte low
		host.send_cmd(`HLB_CMD_ISO_RD); // read from start
		for (k = 0; k < 9; k++) begin
			host.read_word(w, k > 6);
			`CHECK(w, pat(k, 1'b0)); // word order
			if (k == 7) begin
				step(2);
				`CHECK(eot_n - e0, 1); // no end before count
			end
		end
		step(2);
		`CHECK(eot_n - e0, 2); // end on last word
		`CHECK(buffer_status_flags, 6'h02); // status updated
		sie_wr_en = 1'b1;
		byte_transfer_counter = 16'h0100;
		host.send_cmd(`HLB_CMD_ACK_WR); // write command
		k = 0;
		while (wr_ready === 1'b1 && k < 40) begin
			host.write_word(16'h0F0F, 1'b0);
			k++;
		end
		host.release_bus();
		`CHECK(k, `HLB_FIFO_DEPTH); // words queued behind controller
		sie_wr_en = 1'b0;
		drain();
		byte_transfer_counter = 16'h0006;
		e0 = eot_n;
		host.send_cmd(`HLB_CMD_ACK_WR); // restart pointer
		for (k = 0; k < 3; k++)
			host.write_word(pat(k, 1'b1), k == 2); // consecutive words
		drain();
		peek(12'h040, 8'h50); // even byte low
		peek(12'h045, 8'h55); // odd byte high
		`CHECK(buffer_status_flags, 6'h06); // ack full set
		host.send_cmd(`HLB_CMD_ACK_RD); // read command
		for (k = 0; k < 3; k++) begin
			host.read_word(w, k == 2);
			`CHECK(w, pat(k, 1'b1)); // word order
		end
		step(2);
		`CHECK(eot_n - e0, 2); // one end per burst
		`CHECK(buffer_status_flags, 6'h02); // ack full cleared
		sie_consumed = 3'b100;
		step(1);
		sie_consumed = 3'b000;
		step(1);
		`CHECK(buffer_status_flags, 6'h22); // ack done set
		host.send_cmd(`HLB_CMD_ACK_WR);
		step(1);
		`CHECK(buffer_status_flags, 6'h02); // ack done cleared
		iso_half_sel = 1'b1;
		byte_transfer_counter = 16'h0004;
		e0 = eot_n;
		host.send_cmd(`HLB_CMD_ISO_WR); // half one write
		for (k = 0; k < 2; k++)
			host.write_word(pat(k + 4, 1'b0), k == 1); // whole words
		drain();
		peek(12'h020, 8'h18); // half one after half zero
		peek(12'h021, 8'h19); // half one odd byte low
		host.send_cmd(`HLB_CMD_ISO_RD); // half one read
		for (k = 0; k < 2; k++) begin
			host.read_word(w, k == 1);
			`CHECK(w, pat(k + 4, 1'b0)); // half one words
		end
		step(2);
		`CHECK(eot_n - e0, 2); // one end per direction
		`CHECK(buffer_status_flags, 6'h00); // half one full cleared
		ack_buffer_length = 16'h0800;
		iso_buffer_length = 16'h0400;
		step(1);
		`CHECK(cfg_overflow, 0); // exactly at limit
		iso_buffer_length = 16'h0401;
		step(1);
		`CHECK(cfg_overflow, 1); // beyond limit
		`CHECK(irq_n, eot_n); // interrupt follows end
		complete_run();
	end
endmodule
